// file: hdl/spi_slave_engine.sv
// serial peripheral slave engine with status flags
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/100ps
module spi_slave_engine
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic sck,
  input wire logic mosi,
  input wire logic slave_select_n,
  output logic miso_out,
  output logic miso_oe,
  input wire logic interface_enable_set,
  input wire logic interface_enable_clr,
  input wire logic master_enable_set,
  input wire logic master_enable_clr,
  input wire logic select_mode_hi,
  input wire logic select_mode_lo,
  input wire logic clock_phase_bit,
  input wire logic clock_polarity_bit,
  input wire logic [7:0] serial_rate_reg,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic data_rd,
  input wire logic done_clr,
  input wire logic collision_clr,
  input wire logic fault_clr,
  input wire logic overrun_clr,
  output logic [7:0] rx_data,
  output logic interface_enable_bit,
  output logic master_enable_bit,
  output logic xfer_done_flag,
  output logic write_collision_flag,
  output logic master_fault_flag,
  output logic rx_overrun_flag,
  output logic tx_buf_empty,
  output logic busy,
  output logic [7:0] master_rate_div
);
  logic sck_lvl;
  logic sck_rise;
  logic sck_fall;
  logic ss_lvl;
  logic ss_fall;
  logic mosi_lvl;
  logic [1:0] select_mode;
  logic slave_mode;
  logic selected;
  logic sck_edge_ok;
  logic lead_edge;
  logic trail_edge;
  logic sample_edge;
  logic shift_edge;
  logic byte_end;
  logic mode_fault;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_buf_reg;
  logic shift_full_reg;
  logic active_reg;
  logic rx_full_reg;
  logic sampled_bit_reg;
  logic [7:0] rx_next;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  sync_edge #(.INIT(1'b0)) u_sck_sync
  (
    .core_clk(core_clk),
    .srst(srst),
    .async_in(sck),
    .level(sck_lvl),
    .rise(sck_rise),
    .fall(sck_fall)
  );

  sync_edge #(.INIT(1'b1)) u_ss_sync
  (
    .core_clk(core_clk),
    .srst(srst),
    .async_in(slave_select_n),
    .level(ss_lvl),
    .rise(),
    .fall(ss_fall)
  );

  sync_edge #(.INIT(1'b0)) u_mosi_sync
  (
    .core_clk(core_clk),
    .srst(srst),
    .async_in(mosi),
    .level(mosi_lvl),
    .rise(),
    .fall()
  );

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  assign select_mode = {select_mode_hi, select_mode_lo};
  assign slave_mode = interface_enable_bit & ~master_enable_bit;
  // three-wire: always selected; four-wire: selected while select low
  assign selected = (select_mode == spi_slave_pkg::SELECT_MODE_3WIRE) ? 1'b1 :
    (select_mode == spi_slave_pkg::SELECT_MODE_4WIRE) ? ~ss_lvl : 1'b0;
  assign sck_edge_ok = slave_mode & selected;
  // leading edge is rising when idle low; polarity flips it
  assign lead_edge = clock_polarity_bit ? sck_fall : sck_rise;
  assign trail_edge = clock_polarity_bit ? sck_rise : sck_fall;
  assign sample_edge = sck_edge_ok & (clock_phase_bit ? trail_edge : lead_edge);
  assign shift_edge = sck_edge_ok & (clock_phase_bit ? lead_edge : trail_edge);
  assign byte_end = sample_edge & (bit_cnt_reg == spi_slave_pkg::BIT_COUNT_LAST);
  assign mode_fault = master_enable_bit & interface_enable_bit &
    (select_mode == spi_slave_pkg::SELECT_MODE_4WIRE) & ~ss_lvl;
  assign rx_next = {shift_reg[6:0], mosi_lvl};

  // ------------------------------------------------------------
  // enables; a mode fault clears both
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      interface_enable_bit <= 1'b0;
      master_enable_bit <= 1'b0;
    end
    else if (mode_fault)
    begin
      interface_enable_bit <= 1'b0;
      master_enable_bit <= 1'b0;
    end
    else
    begin
      if (interface_enable_set)
        interface_enable_bit <= 1'b1;
      else if (interface_enable_clr)
        interface_enable_bit <= 1'b0;
      if (master_enable_set)
        master_enable_bit <= 1'b1;
      else if (master_enable_clr)
        master_enable_bit <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // bit counter
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst || !interface_enable_bit)
      bit_cnt_reg <= spi_slave_pkg::BIT_COUNT_RESET;
    else if (select_mode == spi_slave_pkg::SELECT_MODE_4WIRE && ss_fall)
      bit_cnt_reg <= spi_slave_pkg::BIT_COUNT_RESET;
    else if (sample_edge)
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
  end

  // ------------------------------------------------------------
  // transfer activity: set on first edge, ends with the byte
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst || !interface_enable_bit)
      active_reg <= 1'b0;
    else if (byte_end || (select_mode == spi_slave_pkg::SELECT_MODE_4WIRE && ss_fall))
      active_reg <= 1'b0;
    else if (sample_edge || (shift_edge && clock_phase_bit))
      active_reg <= 1'b1;
  end

  // ------------------------------------------------------------
  // transmit buffer and shift register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      tx_buf_reg <= spi_slave_pkg::DATA_RESET;
      tx_buf_empty <= 1'b1;
      shift_reg <= spi_slave_pkg::DATA_RESET;
      shift_full_reg <= 1'b0;
      sampled_bit_reg <= 1'b0;
    end
    else
    begin
      if (sample_edge)
        sampled_bit_reg <= mosi_lvl;
      if (byte_end)
      begin
        shift_reg <= tx_buf_empty ? rx_next : tx_buf_reg;
        shift_full_reg <= ~tx_buf_empty;
        tx_buf_empty <= 1'b1;
      end
      else
      begin
        if (shift_edge && bit_cnt_reg != spi_slave_pkg::BIT_COUNT_RESET)
          shift_reg <= {shift_reg[6:0], sampled_bit_reg};
        if (data_wr && tx_buf_empty)
        begin
          // empty idle shifter takes the byte at once; a frozen one waits
          if (!shift_full_reg && !active_reg)
          begin
            shift_reg <= data_wdata;
            shift_full_reg <= 1'b1;
          end
          else
          begin
            tx_buf_reg <= data_wdata;
            tx_buf_empty <= 1'b0;
          end
        end
        else if (!tx_buf_empty && !shift_full_reg && !active_reg)
        begin
          shift_reg <= tx_buf_reg;
          shift_full_reg <= 1'b1;
          tx_buf_empty <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // receive buffer with overrun protection
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rx_data <= spi_slave_pkg::DATA_RESET;
      rx_full_reg <= 1'b0;
    end
    else if (byte_end && (!rx_full_reg || data_rd))
    begin
      rx_data <= rx_next;
      rx_full_reg <= 1'b1;
    end
    else if (data_rd)
      rx_full_reg <= 1'b0;
  end

  // ------------------------------------------------------------
  // sticky flags: a set in the clear cycle wins
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      xfer_done_flag <= 1'b0;
      write_collision_flag <= 1'b0;
      master_fault_flag <= 1'b0;
      rx_overrun_flag <= 1'b0;
    end
    else
    begin
      xfer_done_flag <= byte_end | (xfer_done_flag & ~done_clr);
      write_collision_flag <= (data_wr & ~tx_buf_empty) | (write_collision_flag & ~collision_clr);
      master_fault_flag <= mode_fault | (master_fault_flag & ~fault_clr);
      rx_overrun_flag <= (byte_end & rx_full_reg & ~data_rd) | (rx_overrun_flag & ~overrun_clr);
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      busy <= 1'b0;
      master_rate_div <= spi_slave_pkg::RATE_RESET;
    end
    else
    begin
      miso_out <= shift_reg[7];
      miso_oe <= slave_mode & selected;
      busy <= active_reg;
      // only a master would use it; slave timing follows the far clock alone
      master_rate_div <= (serial_rate_reg < 8'(spi_slave_pkg::MASTER_MIN_DIV_HALF)) ?
        8'(spi_slave_pkg::MASTER_MIN_DIV_HALF) : serial_rate_reg;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_done_on_byte: assert property (@(posedge core_clk) disable iff (srst)
    byte_end |=> xfer_done_flag)
    else $error("done flag not set after byte");
  a_done_sticky: assert property (@(posedge core_clk) disable iff (srst)
    xfer_done_flag && !done_clr |=> xfer_done_flag)
    else $error("done flag cleared without software");
  a_collision_keep: assert property (@(posedge core_clk) disable iff (srst)
    data_wr && !tx_buf_empty && !byte_end |=> write_collision_flag && tx_buf_reg == $past(tx_buf_reg))
    else $error("colliding write altered buffer");
  a_fault_disables: assert property (@(posedge core_clk) disable iff (srst)
    mode_fault |=> master_fault_flag && !interface_enable_bit && !master_enable_bit)
    else $error("mode fault did not disable");
  a_overrun_keeps: assert property (@(posedge core_clk) disable iff (srst)
    byte_end && rx_full_reg && !data_rd |=> rx_overrun_flag && $stable(rx_data))
    else $error("overrun replaced receive byte");
  a_ss_clears_cnt: assert property (@(posedge core_clk) disable iff (srst)
    interface_enable_bit && select_mode == spi_slave_pkg::SELECT_MODE_4WIRE && ss_fall
      |=> bit_cnt_reg == spi_slave_pkg::BIT_COUNT_RESET)
    else $error("select fall did not clear counter");
  a_sck_ignored: assert property (@(posedge core_clk) disable iff (srst)
    select_mode == spi_slave_pkg::SELECT_MODE_4WIRE && ss_lvl && interface_enable_bit
      |=> $stable(bit_cnt_reg))
    else $error("counter moved while unselected");
  a_miso_tristate: assert property (@(posedge core_clk) disable iff (srst)
    !interface_enable_bit ##1 !interface_enable_bit |-> !miso_oe)
    else $error("data-out driven while disabled");
endmodule // spi_slave_engine

// file: hdl/spi_slave_pkg.sv
// constants shared by the serial slave engine
package spi_slave_pkg;
  // ------------------------------------------------------------
  // select-mode encodings {select_mode_hi, select_mode_lo}
  // ------------------------------------------------------------
  localparam logic [1:0] SELECT_MODE_3WIRE = 2'h0;
  localparam logic [1:0] SELECT_MODE_4WIRE = 2'h1;
  localparam logic [1:0] SELECT_MODE_RESET = 2'h1;
  // ------------------------------------------------------------
  // byte framing and reset values
  // ------------------------------------------------------------
  localparam int BITS_PER_BYTE = 8;
  localparam logic [2:0] BIT_COUNT_LAST = 3'h7;
  localparam logic [2:0] BIT_COUNT_RESET = 3'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // ------------------------------------------------------------
  // master rate limit: lower of half the core clock and 12.5 MHz
  // ------------------------------------------------------------
  localparam int CORE_CLK_KHZ = 200000;
  localparam int MASTER_MAX_KHZ = 12500;
  localparam int MASTER_MIN_DIV_HALF = CORE_CLK_KHZ / 2 > MASTER_MAX_KHZ ?
    (CORE_CLK_KHZ + 2 * MASTER_MAX_KHZ - 1) / (2 * MASTER_MAX_KHZ) : 1;
  localparam logic [7:0] RATE_RESET = 8'h00;
endpackage

// file: hdl/sync_edge.sv
// two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/100ps
module sync_edge
#(
  parameter logic INIT = 1'b0
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // ------------------------------------------------------------
  // synchroniser; the first stage feeds only the second
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      meta_reg <= INIT;
      sync_reg <= INIT;
      prev_reg <= INIT;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;
endmodule // sync_edge

// file: test/spi_master_model.sv
// behavioural serial bus master that drives clock, select and data into the slave
`timescale 1ns/100ps
module spi_master_model
(
  output logic sck,
  output logic mosi,
  output logic slave_select_n,
  input wire logic miso
);
  // ------------------------------------------------------------
  // bus tasks, 80 ns bit period (16 core clocks)
  // ------------------------------------------------------------
  initial
  begin
    sck = 1'b0;
    mosi = 1'b0;
    slave_select_n = 1'b1;
  end
  // a released data line shows the inverse of its last bit, never a stale copy
  task automatic idle(input logic pol);
    sck = pol;
    mosi = ~mosi;
  endtask
  task automatic sel(input logic v);
    slave_select_n = v;
    #40;
  endtask
  // clock stands still at its idle level outside frames
  task automatic shift(input logic [7:0] tx, input logic pha, input logic pol, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--)
    begin
      if (!pha) mosi = tx[i];
      #40 sck = ~pol;
      if (pha) mosi = tx[i];
      else rx = {rx[6:0], miso};
      #40 sck = pol;
      if (pha) rx = {rx[6:0], miso};
    end
    #40;
    mosi = ~mosi;
  endtask
endmodule // spi_master_model

// file: test/spi_slave_engine_with_flags_tb_top.sv
// self-checking bench for the serial slave engine
`timescale 1ns/100ps
module spi_slave_engine_with_flags_tb_top;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  typedef struct {logic [1:0] mode; logic ph; logic po; logic [7:0] s_tx; logic [7:0] m_tx;} row_s;
  logic core_clk = 1'b0, srst = 1'b1, sck, mosi, slave_select_n, miso_out, miso_oe;
  logic interface_enable_set = 0, interface_enable_clr = 0, master_enable_set = 0, master_enable_clr = 0;
  logic select_mode_hi = 0, select_mode_lo = 1, clock_phase_bit = 0, clock_polarity_bit = 0;
  logic data_wr = 0, data_rd = 0, done_clr = 0, collision_clr = 0, fault_clr = 0, overrun_clr = 0;
  logic [7:0] data_wdata = 8'h00, rx_data, got;
  logic [7:0] serial_rate_reg = 8'h03, master_rate_div;
  logic interface_enable_bit, master_enable_bit, xfer_done_flag, write_collision_flag;
  logic master_fault_flag, rx_overrun_flag, tx_buf_empty, busy;
  int n_errors = 0, n_checks = 0;
  // a released pin shows the inverse of the last bit, so a stale copy cannot pass
  wire miso_w = miso_oe ? miso_out : ~miso_out;
  row_s rows[6] = '{'{2'h1, 0, 0, 8'ha5, 8'h3c}, '{2'h1, 1, 0, 8'h81, 8'h7e}, '{2'h1, 0, 1, 8'h5a, 8'hc3},
    '{2'h1, 1, 1, 8'h01, 8'h80}, '{2'h0, 0, 0, 8'hf0, 8'h0f}, '{2'h0, 1, 1, 8'h96, 8'h69}};
  spi_slave_engine spi_slave_engine_i (.core_clk, .srst, .sck, .mosi, .slave_select_n, .miso_out, .miso_oe,
    .interface_enable_set, .interface_enable_clr, .master_enable_set, .master_enable_clr, .select_mode_hi,
    .select_mode_lo, .clock_phase_bit, .clock_polarity_bit, .serial_rate_reg, .data_wr, .data_wdata,
    .data_rd, .done_clr, .collision_clr, .fault_clr, .overrun_clr, .rx_data, .interface_enable_bit,
    .master_enable_bit, .xfer_done_flag, .write_collision_flag, .master_fault_flag, .rx_overrun_flag,
    .tx_buf_empty, .busy, .master_rate_div);
  spi_master_model spi_master_model_i (.sck, .mosi, .slave_select_n, .miso(miso_w));
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick;
    s = 1'b0;
    tick;
  endtask
  task automatic wr_byte(input logic [7:0] d);
    data_wdata = d;
    pulse(data_wr);
  endtask
  // disable around every change of phase or polarity
  task automatic setup(input logic [1:0] mode, input logic ph, input logic po);
    pulse(interface_enable_clr);
    {select_mode_hi, select_mode_lo} = mode;
    clock_phase_bit = ph;
    clock_polarity_bit = po;
    spi_master_model_i.idle(po);
    // the new idle level crosses the synchroniser while still disabled
    repeat (3) tick;
    pulse(interface_enable_set);
    repeat (3) tick;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic four);
    if (four) spi_master_model_i.sel(1'b0);
    spi_master_model_i.shift(tx, clock_phase_bit, clock_polarity_bit, 8, got);
    if (four) spi_master_model_i.sel(1'b1);
    repeat (4) tick;
  endtask
  task automatic chk_reset;
    check(tx_buf_empty, 1'b1);
    check(xfer_done_flag, 1'b0);
    check(interface_enable_bit, 1'b0);
    check(rx_data, 8'h00);
    check(miso_oe, 1'b0);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    #200000;
    n_errors++;
    give_verdict;
  end
  initial
  begin
    repeat (2) tick;
    srst = 1'b0;
    tick;
    chk_reset;
    check(master_rate_div, 8'(spi_slave_pkg::MASTER_MIN_DIV_HALF));
    foreach (rows[i])
    begin
      setup(rows[i].mode, rows[i].ph, rows[i].po);
      wr_byte(rows[i].s_tx);
      xfer(rows[i].m_tx, rows[i].mode == 2'h1);
      check(got, rows[i].s_tx);
      check(rx_data, rows[i].m_tx);
      check(xfer_done_flag, 1'b1);
      check(miso_oe, rows[i].mode == 2'h0);
      check(busy, 1'b0);
      pulse(data_rd);
      pulse(done_clr);
      check(xfer_done_flag, 1'b0);
    end
    setup(2'h1, 0, 0);
    spi_master_model_i.shift(8'hff, 0, 0, 8, got);
    repeat (4) tick;
    check(xfer_done_flag, 1'b0);
    spi_master_model_i.sel(1'b0);
    spi_master_model_i.shift(8'h00, 0, 0, 3, got);
    spi_master_model_i.sel(1'b1);
    check(busy, 1'b1);
    wr_byte(8'h77);
    check(tx_buf_empty, 1'b0);
    xfer(8'h5b, 1'b1);
    check(got, 8'h77);
    check(rx_data, 8'h5b);
    pulse(data_rd);
    wr_byte(8'h11);
    check(tx_buf_empty, 1'b1);
    wr_byte(8'h22);
    check(tx_buf_empty, 1'b0);
    wr_byte(8'h33);
    check(write_collision_flag, 1'b1);
    xfer(8'h44, 1'b1);
    check(got, 8'h11);
    check(tx_buf_empty, 1'b1);
    xfer(8'h55, 1'b1);
    check(got, 8'h22);
    check(rx_data, 8'h44);
    check(rx_overrun_flag, 1'b1);
    pulse(collision_clr);
    pulse(overrun_clr);
    pulse(data_rd);
    check(write_collision_flag | rx_overrun_flag, 1'b0);
    pulse(master_enable_set);
    spi_master_model_i.sel(1'b0);
    repeat (4) tick;
    check({master_fault_flag, master_enable_bit, interface_enable_bit}, 3'h4);
    spi_master_model_i.sel(1'b1);
    pulse(fault_clr);
    check(master_fault_flag, 1'b0);
    pulse(master_enable_set);
    check(master_enable_bit, 1'b1);
    pulse(master_enable_clr);
    check(master_enable_bit, 1'b0);
    setup(2'h0, 0, 0);
    spi_master_model_i.shift(8'h00, 0, 0, 3, got);
    setup(2'h0, 0, 0);
    xfer(8'hc9, 1'b0);
    check(rx_data, 8'hc9);
    pulse(done_clr);
    serial_rate_reg = 8'h20;
    setup(2'h2, 0, 0);
    spi_master_model_i.shift(8'h00, 0, 0, 8, got);
    repeat (4) tick;
    check(xfer_done_flag, 1'b0);
    check(miso_oe, 1'b0);
    check(master_rate_div, 8'h20);
    srst = 1'b1;
    tick;
    srst = 1'b0;
    tick;
    chk_reset;
    give_verdict;
  end
endmodule // spi_slave_engine_with_flags_tb_top
